// [shfs_top.sv]
// System handler state, priorities and memory fault status with bus slave
`timescale 1ns/1ps
// Function
// - Hold tick and deferred-call priority bytes
// - Enable bits for usage, bus, memory faults
// - Disabled fault handler escalates to hard fault
// - Report pending bits for four exceptions
// - Software write sets pending bits directly
// - Report active bits of system handlers
// - Software write changes active bits
// - Fetch from non-executable location flags violation
// - Fetch violation captures no fault address
// - Stacked return pc points at faulting instruction
// - Data violation flags and captures attempted address
// - Unstacking fault keeps frame, no save, no address
// - Stacking fault still adjusts sp, no address
// - Lazy floating-point save fault sets flag
// - Address valid only while address is valid
module shfs_top #(
   parameter int PRIO_BITS = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // Register bus write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // Register bus write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // Register bus read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // Register bus read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Core events
   input wire shfs_pkg::shfs_fault_evt_t fault_evt,
   input wire shfs_pkg::shfs_exc_evt_t exc_evt,
   // Core directions
   output shfs_pkg::shfs_route_t fault_route,
   output shfs_pkg::shfs_stack_t stack_ctl,
   output logic [7:0] tick_handler_priority,
   output logic [7:0] deferred_call_priority,
   output logic [31:0] handler_state,
   // Interrupt
   output logic irq
);
   import shfs_pkg::*;

   // Write channel states, gray along idle-address-response
   typedef enum logic [1:0] {
      WS_IDLE = 2'b00,
      WS_HAVE_ADDR = 2'b01,
      WS_RESP = 2'b11,
      WS_HAVE_DATA = 2'b10
   } shfs_wstate_t;

   // Merge written bytes into an old word under byte strobes
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
      input logic [31:0] new_w, input logic [3:0] strb);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Active bit of a system exception number
   function automatic logic [31:0] active_mask(input logic [3:0] num);
      logic [31:0] m;
      m = RESET_WORD;
      case (num)
         EXC_MEM: m[MEM_ACT_BIT] = 1'b1;
         EXC_BUS: m[BUS_ACT_BIT] = 1'b1;
         EXC_USG: m[USG_ACT_BIT] = 1'b1;
         EXC_SVC: m[SVC_ACT_BIT] = 1'b1;
         EXC_MON: m[MON_ACT_BIT] = 1'b1;
         EXC_CALL: m[CALL_ACT_BIT] = 1'b1;
         EXC_TICK: m[TICK_ACT_BIT] = 1'b1;
         default: m = RESET_WORD;
      endcase
      return m;
   endfunction

   // Pending bit of a system exception number
   function automatic logic [31:0] pending_mask(input logic [3:0] num);
      logic [31:0] m;
      m = RESET_WORD;
      case (num)
         EXC_MEM: m[MEM_PEND_BIT] = 1'b1;
         EXC_BUS: m[BUS_PEND_BIT] = 1'b1;
         EXC_USG: m[USG_PEND_BIT] = 1'b1;
         EXC_SVC: m[SVC_PEND_BIT] = 1'b1;
         default: m = RESET_WORD;
      endcase
      return m;
   endfunction

   // Register storage
   logic [PRIO_BITS-1:0] tick_prio_reg; // Implemented tick priority bits
   logic [PRIO_BITS-1:0] call_prio_reg; // Implemented call priority bits
   logic [31:0] ctrl_reg; // Handler control and state word
   logic [7:0] fsr_reg; // Memory fault status byte
   logic [31:0] far_reg; // Memory fault address
   logic [IRQ_W-1:0] irq_stat_reg; // Sticky event bits
   logic [IRQ_W-1:0] irq_mask_reg; // Event enables

   // Bus slave state
   shfs_wstate_t wstate_reg;
   logic [7:0] waddr_reg; // Held write address
   logic [31:0] wdata_reg; // Held write data
   logic [3:0] wstrb_reg; // Held write strobes
   logic rvalid_reg; // Read data outstanding
   logic [31:0] rdata_reg; // Read data
   logic [1:0] rresp_reg; // Read response

   // Decoded internal strobes
   logic wr_fire; // Write applied this cycle
   logic wr_hit; // Write address is mapped
   logic [31:0] wr_word; // Full write data
   logic [31:0] prio_word; // Priority word as read
   logic [31:0] fsr_word; // Fault status word as read
   logic mem_evt; // Any memory management fault
   logic [31:0] ctrl_hw_set; // Hardware pending and active sets
   logic [31:0] ctrl_hw_clr; // Hardware pending and active clears
   logic [7:0] fsr_set; // Hardware fault flag sets
   logic [IRQ_W-1:0] irq_evt; // Interrupt events

   // Assembled read views
   assign prio_word = {tick_prio_reg, {(8-PRIO_BITS){1'b0}},
      call_prio_reg, {(8-PRIO_BITS){1'b0}}, 16'h0000};
   assign fsr_word = {24'h000000, fsr_reg};

   // Write address channel ready while no address held
   assign s_axi_awready = (wstate_reg == WS_IDLE) ||
      (wstate_reg == WS_HAVE_DATA);
   // Write data channel ready while no data held
   assign s_axi_wready = (wstate_reg == WS_IDLE) ||
      (wstate_reg == WS_HAVE_ADDR);
   assign s_axi_bvalid = (wstate_reg == WS_RESP);
   // Response from the held address, settled as soon as bvalid rises
   assign s_axi_bresp = wr_hit ? RESP_OKAY : RESP_DECERR;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // Write channel sequencing, address and data in either order
   always_ff @(posedge clk) begin
      if (rst) begin
         wstate_reg <= WS_IDLE;
         waddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            waddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         case (wstate_reg)
            WS_IDLE: begin
               // Both together, or one of them first
               if (s_axi_awvalid && s_axi_wvalid) begin
                  wstate_reg <= WS_RESP;
               end else if (s_axi_awvalid) begin
                  wstate_reg <= WS_HAVE_ADDR;
               end else if (s_axi_wvalid) begin
                  wstate_reg <= WS_HAVE_DATA;
               end
            end
            WS_HAVE_ADDR: begin
               if (s_axi_wvalid) begin
                  wstate_reg <= WS_RESP;
               end
            end
            WS_HAVE_DATA: begin
               if (s_axi_awvalid) begin
                  wstate_reg <= WS_RESP;
               end
            end
            WS_RESP: begin
               if (s_axi_bready) begin
                  wstate_reg <= WS_IDLE;
               end
            end
            default: wstate_reg <= WS_IDLE;
         endcase
      end
   end

   // Write applied in the cycle after both halves are held
   logic wr_pending_reg; // Held pair not yet applied
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_pending_reg <= 1'b0;
      end else begin
         wr_pending_reg <= (wstate_reg != WS_RESP) &&
            (((wstate_reg == WS_IDLE) && s_axi_awvalid && s_axi_wvalid) ||
            ((wstate_reg == WS_HAVE_ADDR) && s_axi_wvalid) ||
            ((wstate_reg == WS_HAVE_DATA) && s_axi_awvalid));
      end
   end
   assign wr_fire = wr_pending_reg;
   assign wr_word = wdata_reg;

   // Write address decode
   always_comb begin
      if (waddr_reg[7:2] == OFS_PRIO3[7:2]) begin
         wr_hit = 1'b1;
      end else if (waddr_reg[7:2] == OFS_CTRL[7:2]) begin
         wr_hit = 1'b1;
      end else if (waddr_reg[7:2] == OFS_FSR[7:2]) begin
         wr_hit = 1'b1;
      end else if (waddr_reg[7:2] == OFS_FAR[7:2]) begin
         wr_hit = 1'b1;
      end else if (waddr_reg[7:2] == OFS_IRQ_STAT[7:2]) begin
         wr_hit = 1'b1;
      end else if (waddr_reg[7:2] == OFS_IRQ_MASK[7:2]) begin
         wr_hit = 1'b1;
      end else begin
         wr_hit = 1'b0;
      end
   end

   // Read channel, data one cycle after the address is taken
   always_ff @(posedge clk) begin
      if (rst) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= RESET_WORD;
         rresp_reg <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= RESP_OKAY;
         if (s_axi_araddr[7:2] == OFS_PRIO3[7:2]) begin
            rdata_reg <= prio_word;
         end else if (s_axi_araddr[7:2] == OFS_CTRL[7:2]) begin
            rdata_reg <= ctrl_reg;
         end else if (s_axi_araddr[7:2] == OFS_FSR[7:2]) begin
            rdata_reg <= fsr_word;
         end else if (s_axi_araddr[7:2] == OFS_FAR[7:2]) begin
            rdata_reg <= far_reg;
         end else if (s_axi_araddr[7:2] == OFS_IRQ_STAT[7:2]) begin
            rdata_reg <= {{(32-IRQ_W){1'b0}}, irq_stat_reg};
         end else if (s_axi_araddr[7:2] == OFS_IRQ_MASK[7:2]) begin
            rdata_reg <= {{(32-IRQ_W){1'b0}}, irq_mask_reg};
         end else begin
            // Unmapped address answers zero with decode error
            rdata_reg <= RESET_WORD;
            rresp_reg <= RESP_DECERR;
         end
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // Priority fields, only upper bits stored, low bits read zero
   always_ff @(posedge clk) begin
      if (rst) begin
         tick_prio_reg <= '0;
         call_prio_reg <= '0;
      end else if (wr_fire && (waddr_reg[7:2] == OFS_PRIO3[7:2])) begin
         if (wstrb_reg[3]) begin
            tick_prio_reg <= wr_word[31 -: PRIO_BITS];
         end
         if (wstrb_reg[2]) begin
            call_prio_reg <= wr_word[23 -: PRIO_BITS];
         end
      end
   end

   // Any memory management fault event
   assign mem_evt = fault_evt.fetch_viol | fault_evt.data_viol |
      fault_evt.unstack_viol | fault_evt.stack_viol |
      fault_evt.lazy_fp_viol;

   // Hardware sets and clears of pending and active bits
   always_comb begin
      ctrl_hw_set = RESET_WORD;
      ctrl_hw_clr = RESET_WORD;
      // Enabled faults become pending, disabled ones escalate
      ctrl_hw_set[MEM_PEND_BIT] = mem_evt && ctrl_reg[MEM_ENA_BIT];
      ctrl_hw_set[BUS_PEND_BIT] = fault_evt.bus_fault &&
         ctrl_reg[BUS_ENA_BIT];
      ctrl_hw_set[USG_PEND_BIT] = fault_evt.usage_fault &&
         ctrl_reg[USG_ENA_BIT];
      ctrl_hw_set[SVC_PEND_BIT] = exc_evt.svc_request;
      // Entry makes a handler active and ends its pending state
      if (exc_evt.entry_valid) begin
         ctrl_hw_set = ctrl_hw_set | active_mask(exc_evt.entry_num);
         ctrl_hw_clr = pending_mask(exc_evt.entry_num);
      end
      // Return ends the active state
      if (exc_evt.return_valid) begin
         ctrl_hw_clr = ctrl_hw_clr | active_mask(exc_evt.return_num);
      end
   end

   // Control word: software writes values, hardware sets win
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_reg <= RESET_WORD;
      end else if (wr_fire && (waddr_reg[7:2] == OFS_CTRL[7:2])) begin
         // Written pending and active bits take the value
         ctrl_reg <= (merge_bytes(ctrl_reg, wr_word, wstrb_reg) &
            CTRL_IMPL_MASK) | ctrl_hw_set;
      end else begin
         // Entry, return and fault events
         ctrl_reg <= ((ctrl_reg & ~ctrl_hw_clr) | ctrl_hw_set) &
            CTRL_IMPL_MASK;
      end
   end

   // Fault flag sets from the core
   always_comb begin
      fsr_set = 8'h00;
      fsr_set[FETCH_VIOL_BIT] = fault_evt.fetch_viol;
      fsr_set[DATA_VIOL_BIT] = fault_evt.data_viol;
      fsr_set[UNSTACK_BIT] = fault_evt.unstack_viol;
      fsr_set[STACK_BIT] = fault_evt.stack_viol;
      fsr_set[LAZY_FP_BIT] = fault_evt.lazy_fp_viol;
      fsr_set[ADDR_VALID_BIT] = fault_evt.data_viol;
   end

   // Fault status byte, write one to clear, set wins
   always_ff @(posedge clk) begin
      if (rst) begin
         fsr_reg <= 8'h00;
      end else if (wr_fire && (waddr_reg[7:2] == OFS_FSR[7:2]) &&
         wstrb_reg[0]) begin
         fsr_reg <= (fsr_reg & ~wr_word[7:0]) | fsr_set;
      end else if (wr_fire && (waddr_reg[7:2] == OFS_FAR[7:2]) &&
         !fault_evt.data_viol) begin
         // Overwritten address is no longer a fault address
         fsr_reg <= (fsr_reg & ~(8'h01 << ADDR_VALID_BIT)) | fsr_set;
      end else begin
         fsr_reg <= fsr_reg | fsr_set;
      end
   end

   // Fault address, captured only for data violations
   always_ff @(posedge clk) begin
      if (rst) begin
         far_reg <= RESET_WORD;
      end else if (fault_evt.data_viol) begin
         far_reg <= fault_evt.data_addr;
      end else if (wr_fire && (waddr_reg[7:2] == OFS_FAR[7:2])) begin
         far_reg <= merge_bytes(far_reg, wr_word, wstrb_reg);
      end
      // Fetch, stacking and unstacking faults leave it
   end

   // Fault routing toward exception entry
   always_ff @(posedge clk) begin
      if (rst) begin
         fault_route <= '0;
      end else begin
         // Disabled handler turns the fault into a hard fault
         fault_route.hard_fault <= (mem_evt && !ctrl_reg[MEM_ENA_BIT]) ||
            (fault_evt.bus_fault && !ctrl_reg[BUS_ENA_BIT]) ||
            (fault_evt.usage_fault &&
            !ctrl_reg[USG_ENA_BIT]);
         fault_route.mem_fault <= mem_evt && ctrl_reg[MEM_ENA_BIT];
         fault_route.bus_fault <= fault_evt.bus_fault &&
            ctrl_reg[BUS_ENA_BIT];
         fault_route.usage_fault <= fault_evt.usage_fault &&
            ctrl_reg[USG_ENA_BIT];
      end
   end

   // Stacking directions for the stacking logic
   always_ff @(posedge clk) begin
      if (rst) begin
         stack_ctl <= '0;
      end else begin
         // Return address is the faulting instruction
         stack_ctl.pc_valid <= fault_evt.fetch_viol || fault_evt.data_viol;
         stack_ctl.pc <= (fault_evt.fetch_viol || fault_evt.data_viol) ?
            fault_evt.fault_pc : stack_ctl.pc;
         // Stacking fault still moves the stack pointer
         stack_ctl.adjust_sp <= fault_evt.stack_viol &&
            !fault_evt.unstack_viol;
         // Unstacking fault keeps the old frame, no save
         stack_ctl.keep_frame <= fault_evt.unstack_viol;
         stack_ctl.new_save <= mem_evt && !fault_evt.unstack_viol;
      end
   end

   // Interrupt events, one per fault flag except address valid, plus escalation
   assign irq_evt = {(mem_evt && !ctrl_reg[MEM_ENA_BIT]) ||
      (fault_evt.bus_fault && !ctrl_reg[BUS_ENA_BIT]) ||
      (fault_evt.usage_fault && !ctrl_reg[USG_ENA_BIT]),
      fsr_set[LAZY_FP_BIT], fsr_set[STACK_BIT], fsr_set[UNSTACK_BIT],
      fsr_set[DATA_VIOL_BIT], fsr_set[FETCH_VIOL_BIT]};

   // Sticky interrupt status, write one to clear, set wins
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_stat_reg <= '0;
      end else if (wr_fire && (waddr_reg[7:2] == OFS_IRQ_STAT[7:2]) &&
         wstrb_reg[0]) begin
         irq_stat_reg <= (irq_stat_reg & ~wr_word[IRQ_W-1:0]) | irq_evt;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_evt;
      end
   end

   // Interrupt mask
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_mask_reg <= '0;
      end else if (wr_fire && (waddr_reg[7:2] == OFS_IRQ_MASK[7:2]) &&
         wstrb_reg[0]) begin
         irq_mask_reg <= wr_word[IRQ_W-1:0];
      end
   end

   // Level interrupt while any unmasked status bit is set
   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_stat_reg | irq_evt) & irq_mask_reg);
      end
   end

   // Handler state and priorities toward the core
   assign tick_handler_priority = prio_word[31:24];
   assign deferred_call_priority = prio_word[23:16];
   assign handler_state = ctrl_reg;

endmodule

// [shfs_pkg.sv]
// Constants, field layouts and carrier types of the system handler block
package shfs_pkg;
   // Register byte offsets on the register bus
   localparam logic [7:0] OFS_PRIO3 = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_FSR = 8'h08;
   localparam logic [7:0] OFS_FAR = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   // Priority word fields
   localparam int TICK_PRIO_LSB = 24;
   localparam int CALL_PRIO_LSB = 16;
   // Handler control and state word fields
   localparam int USG_ENA_BIT = 18;
   localparam int BUS_ENA_BIT = 17;
   localparam int MEM_ENA_BIT = 16;
   localparam int SVC_PEND_BIT = 15;
   localparam int BUS_PEND_BIT = 14;
   localparam int MEM_PEND_BIT = 13;
   localparam int USG_PEND_BIT = 12;
   localparam int TICK_ACT_BIT = 11;
   localparam int CALL_ACT_BIT = 10;
   localparam int MON_ACT_BIT = 8;
   localparam int SVC_ACT_BIT = 7;
   localparam int USG_ACT_BIT = 3;
   localparam int BUS_ACT_BIT = 1;
   localparam int MEM_ACT_BIT = 0;
   localparam logic [31:0] CTRL_IMPL_MASK = 32'h0007FD8B;
   // Fault status word fields
   localparam int FETCH_VIOL_BIT = 0;
   localparam int DATA_VIOL_BIT = 1;
   localparam int UNSTACK_BIT = 3;
   localparam int STACK_BIT = 4;
   localparam int LAZY_FP_BIT = 5;
   localparam int ADDR_VALID_BIT = 7;
   // Interrupt status and mask fields
   localparam int IRQ_W = 6;
   localparam int IRQ_ESCALATE_BIT = 5;
   // Values after reset
   localparam logic [31:0] RESET_WORD = 32'h00000000;
   // System exception numbers seen on entry and return
   localparam logic [3:0] EXC_MEM = 4'h4;
   localparam logic [3:0] EXC_BUS = 4'h5;
   localparam logic [3:0] EXC_USG = 4'h6;
   localparam logic [3:0] EXC_SVC = 4'hB;
   localparam logic [3:0] EXC_MON = 4'hC;
   localparam logic [3:0] EXC_CALL = 4'hE;
   localparam logic [3:0] EXC_TICK = 4'hF;
   // Bus response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // Fault events from the core, one cycle each
   typedef struct packed {
      logic fetch_viol;
      logic data_viol;
      logic unstack_viol;
      logic stack_viol;
      logic lazy_fp_viol;
      logic bus_fault;
      logic usage_fault;
      logic [31:0] data_addr;
      logic [31:0] fault_pc;
   } shfs_fault_evt_t;
   // Exception entry, return and service call events
   typedef struct packed {
      logic svc_request;
      logic entry_valid;
      logic [3:0] entry_num;
      logic return_valid;
      logic [3:0] return_num;
   } shfs_exc_evt_t;
   // Fault routing toward the exception logic
   typedef struct packed {
      logic hard_fault;
      logic mem_fault;
      logic bus_fault;
      logic usage_fault;
   } shfs_route_t;
   // Stacking directions toward the stacking logic
   typedef struct packed {
      logic pc_valid;
      logic [31:0] pc;
      logic adjust_sp;
      logic keep_frame;
      logic new_save;
   } shfs_stack_t;
endpackage

// [shfs_top_chk.sv]
// Checker of handler state and fault status behaviour
`timescale 1ns/1ps
module shfs_top_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Core side
   input wire shfs_pkg::shfs_fault_evt_t fault_evt,
   input wire shfs_pkg::shfs_exc_evt_t exc_evt,
   input wire shfs_pkg::shfs_route_t fault_route,
   input wire shfs_pkg::shfs_stack_t stack_ctl,
   input wire logic [7:0] tick_handler_priority,
   input wire logic [7:0] deferred_call_priority,
   input wire logic [31:0] handler_state
);
   import shfs_pkg::*;
   // One clock domain for all properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_data_pc: assert property (fault_evt.data_viol |=>
      stack_ctl.pc_valid && stack_ctl.pc == $past(fault_evt.fault_pc))
      else $error("data fault pc lost");
   a_fetch_pc: assert property (fault_evt.fetch_viol |=>
      stack_ctl.pc_valid) else $error("fetch fault pc lost");
   a_stack_adj: assert property (fault_evt.stack_viol &&
      !fault_evt.unstack_viol |=> stack_ctl.adjust_sp)
      else $error("stacking fault kept sp");
   a_unstack_keep: assert property (fault_evt.unstack_viol |=>
      stack_ctl.keep_frame && !stack_ctl.adjust_sp && !stack_ctl.new_save)
      else $error("unstacking fault moved frame");
   a_bus_escalate: assert property (fault_evt.bus_fault &&
      !handler_state[BUS_ENA_BIT] |=> fault_route.hard_fault)
      else $error("bus fault not escalated");
   a_mem_pend: assert property (fault_evt.data_viol &&
      handler_state[MEM_ENA_BIT] |=> handler_state[MEM_PEND_BIT])
      else $error("memory fault not pending");
   a_tick_active: assert property (exc_evt.entry_valid &&
      exc_evt.entry_num == EXC_TICK |=> handler_state[TICK_ACT_BIT])
      else $error("tick entry not active");
   a_prio_low: assert property (!tick_handler_priority[3:0] &&
      !deferred_call_priority[3:0]) else $error("priority low bits set");
   a_reset_zero: assert property ($fell(rst) |->
      handler_state == 32'h0) else $error("state not clear after reset");
   // Main scenarios reached
   c_hard: cover property (fault_route.hard_fault);
   c_keep: cover property (stack_ctl.keep_frame);
   c_pend: cover property (handler_state[MEM_PEND_BIT]);
endmodule
bind shfs_top shfs_top_chk u_chk (.clk, .rst, .fault_evt, .exc_evt,
   .fault_route, .stack_ctl, .tick_handler_priority,
   .deferred_call_priority, .handler_state);

// [shfs_core_model.sv]
// Core model that issues fault and exception events
`timescale 1ns/1ps
module shfs_core_model (
   // Clock
   input wire logic clk,
   // Events toward the block
   output shfs_pkg::shfs_fault_evt_t fault_evt,
   output shfs_pkg::shfs_exc_evt_t exc_evt
);
   import shfs_pkg::*;
   // Quiet at start
   initial begin
      fault_evt = '0;
      exc_evt = '0;
   end
   // One cycle event; address turns stale after
   task automatic pulse(input shfs_fault_evt_t f, input shfs_exc_evt_t e);
      shfs_fault_evt_t z;
      z = '0;
      z.data_addr = ~f.data_addr;
      fault_evt <= f;
      exc_evt <= e;
      @(posedge clk);
      fault_evt <= z;
      exc_evt <= '0;
      // Quiet edge, so calls in a row never drive twice at one time
      @(posedge clk);
   endtask
endmodule

// [shfs_top_tb_top.sv]
// Self-checking bench of the system handler block
`timescale 1ns/1ps
module shfs_top_tb_top;
   import shfs_pkg::*;
   logic clk, rst, awv, wv, bry, arv, rry, awr, wr_r, bv, arr, rv, irq;
   logic [7:0] awa, ara, tpr, dpr;
   logic [31:0] wd, rdd, hst;
   logic [1:0] brs, rrs;
   shfs_fault_evt_t fev;
   shfs_exc_evt_t eev;
   shfs_route_t rte;
   shfs_stack_t stk;
   int n_mismatch = 0, tests_run = 0, cyc = 0;
   // Device under test; prot and strobe tied
   shfs_top dut (.clk(clk), .rst(rst), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
      .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_bresp(brs), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .s_axi_rdata(rdd), .s_axi_rresp(rrs),
      .fault_evt(fev), .exc_evt(eev), .fault_route(rte),
      .stack_ctl(stk), .tick_handler_priority(tpr),
      .deferred_call_priority(dpr), .handler_state(hst), .irq(irq));
   shfs_core_model core (.clk(clk), .fault_evt(fev), .exc_evt(eev));
   // 50 MHz clock
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // Register write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'h0;
         if (wr_r) wv <= 1'h0;
      end while (!bv);
      chk({30'h0, brs}, {30'h0, er});
   endtask
   // Register read
   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
      input logic [1:0] er);
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'h0;
      end while (!rv);
      chk(rdd, exp);
      chk({30'h0, rrs}, {30'h0, er});
   endtask
   // Verdict and stop
   task automatic end_sim;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Values after reset, unmapped place
   task automatic t_reset;
      rd(OFS_PRIO3, 32'h0, RESP_OKAY);
      rd(OFS_CTRL, 32'h0, RESP_OKAY);
      rd(OFS_FSR, 32'h0, RESP_OKAY);
      rd(8'h18, 32'h0, RESP_DECERR);
      wr(8'h18, 32'hFFFFFFFF, RESP_DECERR);
   endtask
   // Priority bytes keep upper nibbles only
   task automatic t_prio;
      wr(OFS_PRIO3, 32'hFFFFFFFF, RESP_OKAY);
      rd(OFS_PRIO3, 32'hF0F00000, RESP_OKAY);
      chk({tpr, dpr, 16'h0}, 32'hF0F00000);
   endtask
   // Enable, pending and active bits by software
   task automatic t_ctrl;
      wr(OFS_CTRL, 32'hFFFFFFFF, RESP_OKAY);
      rd(OFS_CTRL, CTRL_IMPL_MASK, RESP_OKAY);
      chk(hst, CTRL_IMPL_MASK);
      wr(OFS_CTRL, 32'h0, RESP_OKAY);
      rd(OFS_CTRL, 32'h0, RESP_OKAY);
   endtask
   // Data violation, disabled then enabled, then entries
   task automatic t_data;
      shfs_fault_evt_t f;
      shfs_exc_evt_t e;
      f = '0;
      e = '0;
      f.data_viol = 1'h1;
      f.data_addr = 32'h20000010;
      f.fault_pc = 32'h00000400;
      core.pulse(f, e);
      rd(OFS_FSR, 32'h82, RESP_OKAY);
      rd(OFS_FAR, 32'h20000010, RESP_OKAY);
      rd(OFS_CTRL, 32'h0, RESP_OKAY);
      wr(OFS_CTRL, 32'h00010000, RESP_OKAY);
      core.pulse(f, e);
      rd(OFS_CTRL, 32'h00012000, RESP_OKAY);
      e.entry_valid = 1'h1;
      e.entry_num = EXC_MEM;
      core.pulse('0, e);
      e.entry_num = EXC_TICK;
      core.pulse('0, e);
      rd(OFS_CTRL, 32'h00010801, RESP_OKAY);
      wr(OFS_FSR, 32'hFF, RESP_OKAY);
      rd(OFS_FSR, 32'h0, RESP_OKAY);
   endtask
   // Fetch, stacking faults and interrupt
   task automatic t_fault;
      shfs_fault_evt_t f;
      f = '0;
      wr(OFS_IRQ_STAT, 32'h3F, RESP_OKAY);
      wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
      wr(OFS_FAR, 32'h0, RESP_OKAY);
      f.fetch_viol = 1'h1;
      f.data_addr = 32'h0000AA00;
      core.pulse(f, '0);
      rd(OFS_FSR, 32'h01, RESP_OKAY);
      rd(OFS_FAR, 32'h0, RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_IRQ_MASK, 32'h01, RESP_OKAY);
      rd(OFS_IRQ_STAT, 32'h01, RESP_OKAY);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_IRQ_STAT, 32'h01, RESP_OKAY);
      rd(OFS_IRQ_STAT, 32'h0, RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      f = '0;
      f.stack_viol = 1'h1;
      f.bus_fault = 1'h1;
      core.pulse(f, '0);
      f = '0;
      f.unstack_viol = 1'h1;
      f.lazy_fp_viol = 1'h1;
      core.pulse(f, '0);
      rd(OFS_FSR, 32'h39, RESP_OKAY);
   endtask
   // Reset in mid-run clears what earlier scenarios left
   task automatic t_rerst;
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      rd(OFS_CTRL, 32'h0, RESP_OKAY);
      rd(OFS_FSR, 32'h0, RESP_OKAY);
      rd(OFS_IRQ_STAT, 32'h0, RESP_OKAY);
   endtask
   // Main sequence
   initial begin
      rst = 1'h1;
      {awv, wv, bry, arv, rry, awa, ara, wd} = '0;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      t_reset;
      t_prio;
      t_ctrl;
      t_data;
      t_fault;
      t_rerst;
      end_sim;
   end
   // Cycle limit against a hang
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         end_sim;
      end
   end
endmodule
